// [shared/rst_ctrl_pkg.sv]
package rst_ctrl_pkg;

   localparam int unsigned N_SOURCES  = 9;
   localparam int unsigned SYNC_DEPTH = 2;
   localparam int unsigned PORT_BITS  = 8;
   localparam int unsigned N_PORTS    = 5;
   localparam int unsigned PC_BITS    = 16;

   // Source bit positions
   localparam int unsigned SRC_POR    = 0;
   localparam int unsigned SRC_PIN    = 1;
   localparam int unsigned SRC_CMP    = 2;
   localparam int unsigned SRC_SW     = 3;
   localparam int unsigned SRC_VMON   = 4;
   localparam int unsigned SRC_WDOG   = 5;
   localparam int unsigned SRC_MCLK   = 6;
   localparam int unsigned SRC_FLASH  = 7;
   localparam int unsigned SRC_USB    = 8;

   localparam logic [PC_BITS-1:0]   RESET_VECTOR = 16'h0000;
   localparam logic [PORT_BITS-1:0] LATCH_RESET  = 8'hFF;
   localparam logic [N_SOURCES-1:0] SRC_NONE     = 9'h000;
   localparam logic [N_SOURCES-1:0] SRC_ALL      = 9'h1FF;

   // Clock selection encoding
   typedef enum logic [1:0] {
      CLK_INTERNAL = 2'h0,
      CLK_LOWFREQ  = 2'h1,
      CLK_EXTERNAL = 2'h2
   } clk_sel_t;

   typedef enum logic [2:0] {
      ST_HOLD    = 3'b001,
      ST_RELEASE = 3'b010,
      ST_RUN     = 3'b100
   } rst_state_t;

   // Reset request sources, one bit each
   typedef struct packed {
      logic usb;
      logic flash;
      logic mclk;
      logic wdog;
      logic vmon;
      logic sw;
      logic cmp;
      logic pin;
      logic por;
   } rst_src_t;

   // Defaults handed to the rest of the chip
   typedef struct packed {
      logic [PC_BITS-1:0] pc_load;
      clk_sel_t           clk_sel;
      logic               wdog_en;
      logic               pullup_en;
   } rst_defaults_t;

endpackage

// [src/rst_sync.sv]
`timescale 1ns/1ps
// Combines sources and releases them in step with sys_clk
module rst_sync
   import rst_ctrl_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic [N_SOURCES-1:0] src_level,
   output logic                      hold_q
);

   logic [SYNC_DEPTH-1:0] rel_q;
   logic                  any_src;

   assign any_src = |src_level;

   // Assert at once, release after the shift register fills with ones
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rel_q  <= '0;
         hold_q <= 1'b1;
      end else if (any_src) begin
         rel_q  <= '0;
         hold_q <= 1'b1;
      end else begin
         rel_q  <= {rel_q[SYNC_DEPTH-2:0], 1'b1};
         hold_q <= ~rel_q[SYNC_DEPTH-1];
      end
   end

endmodule

// [src/system_reset_controller.sv]
`timescale 1ns/1ps
// Summary of operation
// - Core halted while any reset active
// - Registers load defaults; POR-only bits kept otherwise
// - Interrupts and timers disabled during reset
// - RAM contents never touched by reset
// - Port latches one, drivers open-drain
// - Weak pull-ups on during and after reset
// - Power-on, supply monitor drive reset pin
// - Exit clears PC, selects internal oscillator
// - Watchdog enabled and running after reset
// - First fetch at code address zero
// - Nine reset sources accepted
// - Watchdog reset leaves reset pin alone
module system_reset_controller
   import rst_ctrl_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire rst_src_t             src_req,
   input  wire logic                 pullup_clear,
   output logic                      core_halt_q,
   output logic                      sys_rst_q,
   output logic                      por_rst_q,
   output logic                      irq_disable_q,
   output logic                      timer_disable_q,
   output logic                      ram_keep_q,
   output logic [N_PORTS*PORT_BITS-1:0] port_latch_q,
   output logic                      port_open_drain_q,
   output rst_defaults_t             defaults_q,
   output logic                      fetch_start_q,
   output logic                      reset_pin_n_o_q,
   output logic                      reset_pin_n_oe_q,
   output rst_src_t                  last_cause_q
);

   rst_state_t state_q;
   rst_state_t state_d;
   logic       hold_q;
   logic       pin_drive;

   // All nine sources feed the combiner
   rst_sync u_sync (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .src_level (src_req),
      .hold_q    (hold_q)
   );

   // Only supply-related sources drive the pin; watchdog excluded
   assign pin_drive = src_req.por | src_req.vmon;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_HOLD:    if (!hold_q) state_d = ST_RELEASE;
         ST_RELEASE: state_d = hold_q ? ST_HOLD : ST_RUN;
         ST_RUN:     if (hold_q) state_d = ST_HOLD;
         default:    state_d = ST_HOLD;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) state_q <= ST_HOLD;
      else          state_q <= state_d;
   end

   // Core, interrupt and timer holds
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         core_halt_q     <= 1'b1;
         sys_rst_q       <= 1'b1;
         irq_disable_q   <= 1'b1;
         timer_disable_q <= 1'b1;
      end else begin
         core_halt_q     <= (state_d != ST_RUN);
         sys_rst_q       <= (state_d == ST_HOLD);
         irq_disable_q   <= (state_d != ST_RUN);
         timer_disable_q <= (state_d != ST_RUN);
      end
   end

   // POR-only bits reset solely on power-on
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         por_rst_q <= 1'b1;
      end else begin
         por_rst_q <= src_req.por;
      end
   end

   // RAM never cleared by reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) ram_keep_q <= 1'b1;
      else          ram_keep_q <= 1'b1;
   end

   // Port state during reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_latch_q      <= {N_PORTS{LATCH_RESET}};
         port_open_drain_q <= 1'b1;
      end else if (state_d == ST_HOLD) begin
         port_latch_q      <= {N_PORTS{LATCH_RESET}};
         port_open_drain_q <= 1'b1;
      end
   end

   // Exit defaults: PC, clock, watchdog, pull-ups
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         defaults_q.pc_load   <= RESET_VECTOR;
         defaults_q.clk_sel   <= CLK_INTERNAL;
         defaults_q.wdog_en   <= 1'b1;
         defaults_q.pullup_en <= 1'b1;
      end else if (state_d != ST_RUN) begin
         defaults_q.pc_load   <= RESET_VECTOR;
         defaults_q.clk_sel   <= CLK_INTERNAL;
         defaults_q.wdog_en   <= 1'b1;
         defaults_q.pullup_en <= 1'b1;
      end else if (pullup_clear) begin
         defaults_q.pullup_en <= 1'b0;
      end
   end

   // One-cycle start of fetch on release
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) fetch_start_q <= 1'b0;
      else fetch_start_q <= (state_q == ST_RELEASE) && (state_d == ST_RUN);
   end

   // Reset pin drive and cause capture
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reset_pin_n_o_q  <= 1'b0;
         reset_pin_n_oe_q <= 1'b1;
      end else begin
         reset_pin_n_o_q  <= 1'b0;
         // Latched on the first supply-type edge, even before the core halts
         reset_pin_n_oe_q <= pin_drive | (reset_pin_n_oe_q & (state_d != ST_RUN));
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) last_cause_q <= '0;
      else if (|src_req) last_cause_q <= src_req;
   end

   a_halt_in_reset: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (|src_req) |-> ##2 core_halt_q)
      else $error("core not halted under reset");

   a_irq_timer_off: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      core_halt_q |-> (irq_disable_q && timer_disable_q))
      else $error("irq or timer live in reset");

   a_ports_safe: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      sys_rst_q |-> (port_open_drain_q && (&port_latch_q)))
      else $error("ports not safe in reset");

   a_pin_supply: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (src_req.por | src_req.vmon) |=> reset_pin_n_oe_q && !reset_pin_n_o_q)
      else $error("reset pin not driven");

   a_pin_wdog: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (src_req.wdog && !src_req.por && !src_req.vmon && !reset_pin_n_oe_q)
      |=> !reset_pin_n_oe_q)
      else $error("watchdog drove reset pin");

   a_exit_defaults: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      fetch_start_q |-> (defaults_q.pc_load == RESET_VECTOR
                         && defaults_q.clk_sel == CLK_INTERNAL && defaults_q.wdog_en))
      else $error("wrong exit defaults");

   a_pullup_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      core_halt_q |-> defaults_q.pullup_en)
      else $error("pull-ups off in reset");

   a_sync_release: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (src_req == SRC_NONE)[*6] |-> !core_halt_q)
      else $error("reset not released");

   a_por_flag: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      src_req.por |=> por_rst_q ##1 sys_rst_q)
      else $error("power-on bits not reset");

   c_wdog_reset: cover property (@(posedge sys_clk) disable iff (!reset_n)
      src_req.wdog ##[1:10] fetch_start_q);
   c_por_reset: cover property (@(posedge sys_clk) disable iff (!reset_n)
      src_req.por ##[1:10] fetch_start_q);
   c_pullup_off: cover property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(defaults_q.pullup_en));

endmodule

// [sim/reset_source_model.sv]
`timescale 1ns/1ps
// Holds the requested sources as levels for a set number of cycles
module reset_source_model
   import rst_ctrl_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       fire,
   input  wire rst_src_t   fire_src,
   input  wire logic [7:0] fire_len,
   output rst_src_t        src_req
);
   logic [7:0] left_q = 8'h00;
   rst_src_t   held_q = SRC_NONE;
   always @(posedge sys_clk) begin
      if (fire) begin
         held_q <= fire_src;
         left_q <= fire_len;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign src_req = (left_q != 8'h00) ? held_q : SRC_NONE;
endmodule

// [sim/tb_system_reset_controller.sv]
`timescale 1ns/1ps
module tb_system_reset_controller;
   import rst_ctrl_pkg::*;
   logic          sys_clk = 1'b0;
   logic          reset_n = 1'b0;
   logic          pu_clr = 1'b0;
   logic          fire = 1'b0;
   rst_src_t      fsrc = SRC_NONE;
   logic [7:0]    flen = 8'h00;
   rst_src_t      src, cause;
   rst_defaults_t dflt;
   logic          halt, srst, porr, irqd, timd, ramk, odr, fst, pin_o, pin_oe;
   logic [39:0]   latch;
   logic [31:0]   rng = 32'h47;
   int            err_count = 0;
   int            checks = 0;

   always #2.5 sys_clk = ~sys_clk;

   reset_source_model src_u (.sys_clk(sys_clk), .fire(fire), .fire_src(fsrc),
      .fire_len(flen), .src_req(src));

   system_reset_controller dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .src_req(src),
      .pullup_clear(pu_clr), .core_halt_q(halt), .sys_rst_q(srst), .por_rst_q(porr),
      .irq_disable_q(irqd), .timer_disable_q(timd), .ram_keep_q(ramk),
      .port_latch_q(latch), .port_open_drain_q(odr), .defaults_q(dflt),
      .fetch_start_q(fst), .reset_pin_n_o_q(pin_o), .reset_pin_n_oe_q(pin_oe),
      .last_cause_q(cause));

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask

   task automatic give_verdict();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic go(input rst_src_t m, input logic [7:0] len);
      fire = 1'b1;
      fsrc = m;
      flen = len;
      tick();
      fire = 1'b0;
   endtask

   task automatic wait_halt(input logic val, input int lim);
      int n;
      n = 0;
      while (halt !== val && n < lim) begin
         tick();
         n++;
      end
      chk(halt, val, "halt timing");
   endtask

   task automatic pulse_clr();
      pu_clr = 1'b1;
      tick();
      pu_clr = 1'b0;
      tick();
   endtask

   task automatic check_hold(input logic oe);
      chk(halt, 1'b1, "halt");
      chk(srst, 1'b1, "reg reset");
      chk(irqd, 1'b1, "irq off");
      chk(timd, 1'b1, "timer off");
      chk(ramk, 1'b1, "ram kept");
      chk(latch, {N_PORTS{LATCH_RESET}}, "latches");
      chk(odr, 1'b1, "open drain");
      chk(dflt.pullup_en, 1'b1, "pullups");
      chk(pin_oe, oe, "pin drive");
      chk(pin_o, 1'b0, "pin low");
   endtask

   task automatic check_run();
      chk(fst, 1'b1, "fetch start");
      chk(dflt.pc_load, RESET_VECTOR, "pc");
      chk(dflt.clk_sel, CLK_INTERNAL, "clk sel");
      chk(dflt.wdog_en, 1'b1, "wdog on");
      chk(dflt.pullup_en, 1'b1, "pullups kept");
      chk(irqd | timd | srst | porr, 1'b0, "run flags");
      chk(pin_oe, 1'b0, "pin freed");
      chk(ramk & odr, 1'b1, "ram, open drain");
      tick();
      chk(fst, 1'b0, "fetch pulse");
   endtask

   initial begin
      rst_src_t    m;
      int unsigned k;
      repeat (8) tick();
      check_hold(1'b1);
      chk(cause, SRC_NONE, "cause at reset");
      repeat (8) tick();
      reset_n = 1'b1;
      wait_halt(1'b0, 12);
      check_run();
      for (k = 0; k < N_SOURCES; k++) begin
         m = rst_src_t'(9'h001 << k);
         go(m, 8'(1 + xs() % 4));
         wait_halt(1'b1, 6);
         check_hold(m.por | m.vmon);
         chk(cause, m, "cause");
         if (!m.por) chk(porr, 1'b0, "por bits kept");
         wait_halt(1'b0, 16);
         check_run();
      end
      // One-cycle supply-type pulses must still latch the pin drive
      go(rst_src_t'(9'h001 << SRC_POR), 8'h01);
      wait_halt(1'b1, 6);
      check_hold(1'b1);
      wait_halt(1'b0, 16);
      check_run();
      go(rst_src_t'(9'h001 << SRC_VMON), 8'h01);
      wait_halt(1'b1, 6);
      check_hold(1'b1);
      wait_halt(1'b0, 16);
      check_run();
      repeat (10) begin
         m = rst_src_t'(9'(xs()));
         if (m == SRC_NONE) m = SRC_ALL;
         go(m, 8'(2 + xs() % 6));
         wait_halt(1'b1, 6);
         check_hold(m.por | m.vmon);
         chk(cause, m, "cause mix");
         wait_halt(1'b0, 20);
         check_run();
      end
      go(rst_src_t'(9'h001 << SRC_WDOG), 8'h28);
      wait_halt(1'b1, 6);
      repeat (30) begin
         chk(halt, 1'b1, "long hold");
         chk(pin_oe, 1'b0, "wdog pin");
         tick();
      end
      wait_halt(1'b0, 20);
      check_run();
      go(rst_src_t'(9'h001 << SRC_POR), 8'h0A);
      repeat (4) tick();
      chk(porr, 1'b1, "por bits");
      wait_halt(1'b0, 24);
      check_run();
      pulse_clr();
      chk(dflt.pullup_en, 1'b0, "pullups off");
      go(rst_src_t'(9'h001 << SRC_SW), 8'h03);
      wait_halt(1'b1, 6);
      pulse_clr();
      check_hold(1'b0);
      wait_halt(1'b0, 16);
      check_run();
      go(rst_src_t'(9'h001 << SRC_SW), 8'h14);
      wait_halt(1'b1, 6);
      reset_n = 1'b0;
      tick();
      check_hold(1'b1);
      reset_n = 1'b1;
      wait_halt(1'b0, 40);
      check_run();
      give_verdict();
   end

   initial begin
      #40000;
      err_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
